// ### common/panel_pkg.sv
// Shared constants, types and state layout of the printer status panel
package panel_pkg;

  // ***************************************************************
  // Timing
  // ***************************************************************
  localparam int unsigned CLK_HZ = 125_000_000;
  localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;
  localparam int unsigned QUICK_HALF_MS = 125;
  localparam int unsigned SLOW_HALF_MS = 500;
  localparam int unsigned LOCK_S = 1;
  localparam int unsigned HOLD_MS = 500;
  localparam int unsigned REPEAT_MS = 100;
  localparam int unsigned QUICK_HALF_CYCLES = QUICK_HALF_MS * CYC_PER_MS;
  localparam int unsigned SLOW_HALF_CYCLES = SLOW_HALF_MS * CYC_PER_MS;
  localparam int unsigned LOCK_CYCLES = LOCK_S * CLK_HZ;
  localparam int unsigned HOLD_CYCLES = HOLD_MS * CYC_PER_MS;
  localparam int unsigned REPEAT_CYCLES = REPEAT_MS * CYC_PER_MS;
  localparam int unsigned CNT_W = 27;
  typedef logic [CNT_W-1:0] count_type;

  // ***************************************************************
  // Thresholds and decode tables
  // ***************************************************************
  localparam logic [7:0] HOT_C = 8'h41;
  localparam logic [7:0] COOL_C = 8'h3C;
  localparam logic [14:0] BAUD_BASE = 15'h0096;
  typedef enum logic [1:0] {
    DENS_LIGHT = 2'h0, DENS_STANDARD = 2'h1, DENS_DARK = 2'h2, DENS_DARKER = 2'h3
  } density_type;
  typedef enum logic [3:0] {
    CUT_IDLE = 4'h1, CUT_RUN = 4'h2, CUT_LOCK = 4'h4, CUT_INIT = 4'h8
  } cut_state_type;

  // ***************************************************************
  // Switch positions
  // ***************************************************************
  localparam int unsigned SW1_CUTTER = 0;
  localparam int unsigned SW1_COVER_OFF = 1;
  localparam int unsigned SW1_CR_LF = 2;
  localparam int unsigned SW1_COL44 = 4;
  localparam int unsigned SW1_CHARSET = 5;
  localparam int unsigned SW1_DENSITY = 8;
  localparam int unsigned SW2_BITS7 = 0;
  localparam int unsigned SW2_PARITY = 1;
  localparam int unsigned SW2_EVEN = 2;
  localparam int unsigned SW2_XON = 3;
  localparam int unsigned SW2_BAUD = 4;

  // ***************************************************************
  // Register map and fields
  // ***************************************************************
  localparam logic [7:0] CTRL_OFF = 8'h00;
  localparam logic [7:0] STATUS_OFF = 8'h04;
  localparam logic [7:0] SETTINGS_OFF = 8'h08;
  localparam int unsigned CTRL_CUT = 0;
  localparam int unsigned CTRL_MACRO = 1;
  localparam int unsigned SET_BAUD = 16;
  localparam logic [31:0] RDATA_RESET = 32'h0000_0000;

  // ***************************************************************
  // Complete state of the controller
  // ***************************************************************
  typedef struct packed {
    cut_state_type cut;
    count_type lock_cnt;
    logic pos_last;
    logic left_home;
    count_type quick_cnt;
    logic quick_ph;
    count_type slow_cnt;
    logic slow_ph;
    count_type hold_cnt;
    logic key_last;
    logic feeding;
    logic repeating;
    logic key_ignore;
    logic started;
    logic overheat;
    logic macro_wait;
    logic paper_last;
    logic power_lamp;
    logic error_lamp;
    logic print_enable;
    logic line_feed;
    logic load_start;
    logic macro_start;
    logic self_print;
    logic [1:0] density;
    logic [2:0] charset;
    logic col44;
    logic cutter_en;
    logic cover_check;
    logic cr_lf;
    logic bits7;
    logic parity_on;
    logic parity_even;
    logic xon_xoff;
    logic [2:0] baud_idx;
    logic wr_pend;
    logic [7:0] wr_addr;
    logic [31:0] rdata;
  } state_type;

  localparam state_type STATE_RESET = '{cut: CUT_IDLE, default: '0};

endpackage

// ### logic/printer_status_panel_control.sv
// Status lamps, feed key, cutter supervision and switch decode of the printer
`timescale 1ns/1ps
module printer_status_panel_control #(
  parameter int unsigned QUICK_HALF_CYCLES = panel_pkg::QUICK_HALF_CYCLES,
  parameter int unsigned SLOW_HALF_CYCLES = panel_pkg::SLOW_HALF_CYCLES,
  parameter int unsigned LOCK_CYCLES = panel_pkg::LOCK_CYCLES,
  parameter int unsigned HOLD_CYCLES = panel_pkg::HOLD_CYCLES,
  parameter int unsigned REPEAT_CYCLES = panel_pkg::REPEAT_CYCLES
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic mem_check_fail,
  input wire logic cover_open,
  input wire logic [7:0] head_temp,
  input wire logic paper_near_end,
  input wire logic paper_out,
  input wire logic cutter_pos,
  input wire logic cutter_home,
  input wire logic feed_key,
  input wire logic serial_fitted,
  input wire logic [9:0] main_config_switch_bank,
  input wire logic [7:0] serial_config_switch_bank,
  output logic power_lamp,
  output logic error_lamp,
  output logic print_enable,
  output logic line_feed,
  output logic load_start,
  output logic cutter_motor,
  output logic cutter_lock,
  output logic macro_start,
  output logic self_print,
  output logic [1:0] density,
  output logic [2:0] charset,
  output logic col44,
  output logic cutter_enabled,
  output logic cover_check,
  output logic cr_lf,
  output logic serial_bits7,
  output logic parity_on,
  output logic parity_even,
  output logic xon_xoff,
  output logic [14:0] baud_rate
);

  // ***************************************************************
  // Derived counts
  // ***************************************************************
  localparam panel_pkg::count_type QUICK_LAST =
    panel_pkg::count_type'(QUICK_HALF_CYCLES - 1);
  localparam panel_pkg::count_type SLOW_LAST =
    panel_pkg::count_type'(SLOW_HALF_CYCLES - 1);
  localparam panel_pkg::count_type LOCK_LAST =
    panel_pkg::count_type'(LOCK_CYCLES - 1);
  localparam panel_pkg::count_type HOLD_LAST =
    panel_pkg::count_type'(HOLD_CYCLES - 1);
  localparam panel_pkg::count_type REPEAT_LAST =
    panel_pkg::count_type'(REPEAT_CYCLES - 1);

  // Only the word index is compared; upper address bits alias the map
  function automatic logic hits(input logic [7:0] addr,
                                input logic [7:0] off);
    hits = (addr[7:2] == off[7:2]);
  endfunction

  panel_pkg::state_type s_q;
  panel_pkg::state_type s_d;
  logic accept;
  logic press;
  logic release_key;
  logic cover_block;
  logic feed_allowed;
  logic cut_req;
  logic macro_arm;
  logic [31:0] status_word;
  logic [31:0] settings_word;

  // ***************************************************************
  // Bus answers
  // ***************************************************************
  // Zero wait states: every transfer completes in its first data cycle
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = s_q.rdata;

  // ***************************************************************
  // Outputs straight from state
  // ***************************************************************
  assign power_lamp = s_q.power_lamp;
  assign error_lamp = s_q.error_lamp;
  assign print_enable = s_q.print_enable;
  assign line_feed = s_q.line_feed;
  assign load_start = s_q.load_start;
  assign macro_start = s_q.macro_start;
  assign self_print = s_q.self_print;
  assign cutter_motor = (s_q.cut == panel_pkg::CUT_RUN) ||
                        (s_q.cut == panel_pkg::CUT_INIT);
  assign cutter_lock = (s_q.cut == panel_pkg::CUT_LOCK);
  assign density = s_q.density;
  assign charset = s_q.charset;
  assign col44 = s_q.col44;
  assign cutter_enabled = s_q.cutter_en;
  assign cover_check = s_q.cover_check;
  assign cr_lf = s_q.cr_lf;
  assign serial_bits7 = s_q.bits7;
  assign parity_on = s_q.parity_on;
  assign parity_even = s_q.parity_even;
  assign xon_xoff = s_q.xon_xoff;
  assign baud_rate = panel_pkg::BAUD_BASE << s_q.baud_idx;

  // ***************************************************************
  // Readback words
  // ***************************************************************
  assign status_word = {20'h0_0000, s_q.print_enable, s_q.error_lamp,
                        s_q.power_lamp, s_q.macro_wait, s_q.cut,
                        paper_out, paper_near_end, s_q.overheat,
                        cover_open};
  assign settings_word = {13'h0000, s_q.baud_idx, 3'h0, s_q.xon_xoff,
                          s_q.parity_even, s_q.parity_on, s_q.bits7,
                          s_q.cr_lf, s_q.cover_check, s_q.cutter_en,
                          s_q.col44, s_q.charset, s_q.density};

  // ***************************************************************
  // Next state
  // ***************************************************************
  always_comb begin
    s_d = s_q;
    s_d.line_feed = 1'b0;
    s_d.load_start = 1'b0;
    s_d.macro_start = 1'b0;
    s_d.self_print = 1'b0;
    accept = hsel && htrans[1] && hready;
    press = feed_key && !s_q.key_last;
    release_key = !feed_key && s_q.key_last;
    cover_block = cover_open && s_q.cover_check;
    feed_allowed = !cover_block && !mem_check_fail &&
                   (s_q.cut != panel_pkg::CUT_LOCK);
    cut_req = s_q.wr_pend && hits(s_q.wr_addr, panel_pkg::CTRL_OFF) &&
              hwdata[panel_pkg::CTRL_CUT];
    macro_arm = s_q.wr_pend && hits(s_q.wr_addr, panel_pkg::CTRL_OFF) &&
                hwdata[panel_pkg::CTRL_MACRO];

    // Bus slave: capture address phase, read data ready in data phase
    s_d.wr_pend = accept && hwrite;
    s_d.wr_addr = haddr[7:0];
    if (accept && !hwrite) begin
      if (hits(haddr[7:0], panel_pkg::CTRL_OFF)) begin
        s_d.rdata = {30'h0000_0000, s_q.macro_wait, 1'b0};
      end else if (hits(haddr[7:0], panel_pkg::STATUS_OFF)) begin
        s_d.rdata = status_word;
      end else if (hits(haddr[7:0], panel_pkg::SETTINGS_OFF)) begin
        s_d.rdata = settings_word;
      end else begin
        s_d.rdata = panel_pkg::RDATA_RESET;
      end
    end

    // Switch decode, sampled continuously
    s_d.cutter_en = main_config_switch_bank[panel_pkg::SW1_CUTTER];
    s_d.cover_check = !main_config_switch_bank[panel_pkg::SW1_COVER_OFF];
    s_d.cr_lf = main_config_switch_bank[panel_pkg::SW1_CR_LF];
    s_d.col44 = main_config_switch_bank[panel_pkg::SW1_COL44];
    s_d.charset = main_config_switch_bank[panel_pkg::SW1_CHARSET +: 3];
    s_d.density = main_config_switch_bank[panel_pkg::SW1_DENSITY +: 2];
    if (serial_fitted) begin
      s_d.bits7 = serial_config_switch_bank[panel_pkg::SW2_BITS7];
      s_d.parity_on = serial_config_switch_bank[panel_pkg::SW2_PARITY];
      s_d.parity_even = serial_config_switch_bank[panel_pkg::SW2_EVEN];
      s_d.xon_xoff = serial_config_switch_bank[panel_pkg::SW2_XON];
      s_d.baud_idx = serial_config_switch_bank[panel_pkg::SW2_BAUD +: 3];
    end else begin
      // Without the serial port the bank is dead; show neutral values
      s_d.bits7 = 1'b0;
      s_d.parity_on = 1'b0;
      s_d.parity_even = 1'b0;
      s_d.xon_xoff = 1'b0;
      s_d.baud_idx = 3'h0;
    end

    // Blink dividers
    // Both start together at reset, so the lock pattern built from
    // their phases keeps a fixed shape instead of drifting
    if (s_q.quick_cnt == QUICK_LAST) begin
      s_d.quick_cnt = '0;
      s_d.quick_ph = !s_q.quick_ph;
    end else begin
      s_d.quick_cnt = s_q.quick_cnt + 1'b1;
    end
    if (s_q.slow_cnt == SLOW_LAST) begin
      s_d.slow_cnt = '0;
      s_d.slow_ph = !s_q.slow_ph;
    end else begin
      s_d.slow_cnt = s_q.slow_cnt + 1'b1;
    end

    // Head temperature with hysteresis, no operator action needed
    // Between the thresholds the last decision holds, so a head hovering
    // near the limit does not chatter the print gate
    if (head_temp >= panel_pkg::HOT_C) begin
      s_d.overheat = 1'b1;
    end else if (head_temp <= panel_pkg::COOL_C) begin
      s_d.overheat = 1'b0;
    end

    // Paper entering the path starts loading
    s_d.paper_last = paper_out;
    if (s_q.started && s_q.paper_last && !paper_out) begin
      s_d.load_start = 1'b1;
    end

    // Cutter supervision
    // A moving blade toggles the position sensor; one level held for the
    // whole lock span means the motor is stalled
    // Leaving init needs only home: after a jam the blade may sit anywhere,
    // and waiting for it to leave home first could hang the recovery
    s_d.pos_last = cutter_pos;
    case (s_q.cut)
      panel_pkg::CUT_IDLE: begin
        s_d.lock_cnt = '0;
        s_d.left_home = 1'b0;
        if (cut_req && s_q.cutter_en) begin
          s_d.cut = panel_pkg::CUT_RUN;
        end
      end
      panel_pkg::CUT_RUN,
      panel_pkg::CUT_INIT: begin
        if (cutter_pos != s_q.pos_last) begin
          s_d.lock_cnt = '0;
        end else begin
          s_d.lock_cnt = s_q.lock_cnt + 1'b1;
        end
        if (!cutter_home) begin
          s_d.left_home = 1'b1;
        end
        if (s_q.lock_cnt == LOCK_LAST) begin
          s_d.cut = panel_pkg::CUT_LOCK;
        end else if (cutter_home &&
                     (s_q.left_home || s_q.cut == panel_pkg::CUT_INIT)) begin
          s_d.cut = panel_pkg::CUT_IDLE;
        end
      end
      panel_pkg::CUT_LOCK: begin
        s_d.lock_cnt = '0;
        s_d.left_home = 1'b0;
      end
      default: begin
        s_d.cut = panel_pkg::CUT_IDLE;
      end
    endcase

    // Feed key: power-on check, then lock recovery, macro, or feeding
    // A press used for recovery or a macro is ignored until release,
    // so the same press can never feed paper as well
    s_d.key_last = feed_key;
    if (!s_q.started) begin
      s_d.started = 1'b1;
      s_d.key_last = feed_key;
      if (feed_key) begin
        s_d.self_print = 1'b1;
        s_d.key_ignore = 1'b1;
      end
    end else if (press && !s_q.key_ignore) begin
      if (s_q.cut == panel_pkg::CUT_LOCK) begin
        s_d.cut = panel_pkg::CUT_INIT;
        s_d.key_ignore = 1'b1;
      end else if (s_q.macro_wait) begin
        s_d.macro_start = 1'b1;
        s_d.macro_wait = 1'b0;
        s_d.key_ignore = 1'b1;
      end else if (feed_allowed) begin
        s_d.line_feed = 1'b1;
        s_d.feeding = 1'b1;
        s_d.repeating = 1'b0;
        s_d.hold_cnt = '0;
      end
    end else if (release_key) begin
      s_d.feeding = 1'b0;
      s_d.repeating = 1'b0;
      s_d.key_ignore = 1'b0;
    end else if (s_q.feeding && feed_allowed) begin
      // Held key: first repeat after the hold time, then at repeat rate
      if (!s_q.repeating && s_q.hold_cnt == HOLD_LAST) begin
        s_d.line_feed = 1'b1;
        s_d.repeating = 1'b1;
        s_d.hold_cnt = '0;
      end else if (s_q.repeating && s_q.hold_cnt == REPEAT_LAST) begin
        s_d.line_feed = 1'b1;
        s_d.hold_cnt = '0;
      end else begin
        s_d.hold_cnt = s_q.hold_cnt + 1'b1;
      end
    end

    // Arming by software after any key clear, so a same-cycle arm survives
    if (macro_arm) begin
      s_d.macro_wait = 1'b1;
    end

    // Printing gate; a cut in progress also holds the head
    s_d.print_enable = !mem_check_fail && !cover_block &&
                       !s_q.overheat && !paper_out &&
                       (s_q.cut == panel_pkg::CUT_IDLE);

    // Lamps in fixed priority, memory failure first
    s_d.power_lamp = mem_check_fail ? s_q.quick_ph : 1'b1;
    if (mem_check_fail) begin
      s_d.error_lamp = 1'b1;
    end else if (s_q.cut == panel_pkg::CUT_LOCK) begin
      s_d.error_lamp = s_q.quick_ph && s_q.slow_ph;
    end else if (paper_out) begin
      s_d.error_lamp = s_q.quick_ph;
    end else if (cover_open || s_q.overheat) begin
      s_d.error_lamp = 1'b1;
    end else if (paper_near_end) begin
      s_d.error_lamp = 1'b1;
    end else if (s_q.macro_wait) begin
      s_d.error_lamp = s_q.slow_ph;
    end else begin
      s_d.error_lamp = 1'b0;
    end
  end

  // ***************************************************************
  // State register
  // ***************************************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_q <= panel_pkg::STATE_RESET;
    end else begin
      s_q <= s_d;
    end
  end

endmodule // printer_status_panel_control

// ### bench/panel_chk.sv
// Port assertions of the printer status panel controller
`timescale 1ns/1ps
module panel_chk (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic mem_check_fail,
  input wire logic cover_open,
  input wire logic [7:0] head_temp,
  input wire logic paper_out,
  input wire logic serial_fitted,
  input wire logic [7:0] serial_config_switch_bank,
  input wire logic power_lamp,
  input wire logic print_enable,
  input wire logic load_start,
  input wire logic cutter_motor,
  input wire logic cutter_lock,
  input wire logic self_print,
  input wire logic cover_check,
  input wire logic cutter_enabled,
  input wire logic [14:0] baud_rate
);
  // ****
  // Edges since reset, saturating
  // ****
  logic [1:0] age_q;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      age_q <= 2'h0;
    end else if (age_q != 2'h2) begin
      age_q <= age_q + 2'h1;
    end
  end
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  // ****
  // Port relations
  // ****
  chk_power_on: assert property (!mem_check_fail |=> power_lamp)
    else $error("power lamp dark");
  chk_cover_halt: assert property (
    (cover_open && cover_check) ##1 cover_check |-> !print_enable)
    else $error("printing with cover open");
  chk_hot_stop: assert property (
    (head_temp >= 8'h41) ##1 (head_temp > 8'h3c) |=> !print_enable)
    else $error("printing while head hot");
  chk_cool_run: assert property (
    (head_temp <= 8'h3c) ##1 (head_temp <= 8'h3c && !cover_open
    && !paper_out && !mem_check_fail && !cutter_motor && !cutter_lock)
    |=> print_enable)
    else $error("printing not resumed");
  chk_out_stop: assert property (paper_out |=> !print_enable)
    else $error("printing without paper");
  chk_load_pulse: assert property (
    $fell(paper_out) |=> load_start ##1 !load_start)
    else $error("no single load pulse");
  chk_lock_stop: assert property (
    cutter_lock && !mem_check_fail |=> power_lamp && !print_enable)
    else $error("lamp or printing wrong in lock");
  chk_no_cut: assert property (
    !cutter_enabled && !cutter_motor |=> !cutter_motor)
    else $error("cutter started while disabled");
  chk_self_once: assert property (self_print |-> age_q == 2'h1)
    else $error("self print outside power on");
  chk_baud_map: assert property (
    serial_fitted |=>
      baud_rate == 15'h0096 << $past(serial_config_switch_bank[6:4]))
    else $error("baud rate decode wrong");
endmodule // panel_chk

bind printer_status_panel_control panel_chk chk_i (.hclk, .hresetn,
  .mem_check_fail, .cover_open, .head_temp, .paper_out, .serial_fitted,
  .serial_config_switch_bank, .power_lamp, .print_enable, .load_start,
  .cutter_motor, .cutter_lock, .self_print, .cover_check,
  .cutter_enabled, .baud_rate);

// ### bench/cutter_mech.sv
// Cutter mechanism stand-in driving the position and home sensors
`timescale 1ns/1ps
module cutter_mech (
  input wire logic hclk,
  input wire logic cutter_motor,
  input wire logic jam,
  input wire logic [3:0] stroke,
  output logic cutter_pos,
  output logic cutter_home
);
  // ****
  // Blade travel
  // ****
  int steps = 0;
  initial cutter_pos = 1'b0;
  initial cutter_home = 1'b1;
  // A jammed blade freezes both sensors, so the lock timer sees no edge
  always @(posedge hclk) begin
    if (!cutter_motor) begin
      steps <= 0;
    end else if (!jam) begin
      steps <= steps + 1;
      cutter_pos <= ~cutter_pos;
      cutter_home <= steps >= stroke;
    end
  end
endmodule // cutter_mech

// ### bench/testbench.sv
// Self-checking bench of the printer status panel controller
`timescale 1ns/1ps
module testbench;
  localparam int LOCK = 50;
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000;
  logic [31:0] hrdata, r, m, s, seed = 32'h0233_3a36;
  logic hready, hreadyout, hresp, jam = 1'b0;
  logic mem_check_fail = 1'b0, cover_open = 1'b0, paper_out = 1'b0;
  logic paper_near_end = 1'b0, feed_key = 1'b1, serial_fitted = 1'b1;
  logic [7:0] head_temp = 8'h19, serial_config_switch_bank = 8'h00;
  logic [9:0] main_config_switch_bank = 10'h001;
  logic [3:0] stroke = 4'h3;
  logic [7:0] tt [5] = '{8'h40, 8'h41, 8'h3d, 8'h3c, 8'h19};
  logic [4:0] pe = 5'h19;
  logic cutter_pos, cutter_home, power_lamp, error_lamp, print_enable;
  logic line_feed, load_start, cutter_motor, cutter_lock, macro_start;
  logic self_print, col44, cutter_enabled, cover_check, cr_lf;
  logic serial_bits7, parity_on, parity_even, xon_xoff;
  logic [1:0] density;
  logic [2:0] charset;
  logic [14:0] baud_rate;
  int compares = 0, miscompares = 0, lf, ms, on, fl, n, b;

  assign hready = hreadyout;
  printer_status_panel_control #(.QUICK_HALF_CYCLES(4),
    .SLOW_HALF_CYCLES(16), .LOCK_CYCLES(LOCK), .HOLD_CYCLES(40),
    .REPEAT_CYCLES(10)) uut (.*);
  cutter_mech mech (.*);

  initial forever #4 hclk = ~hclk;

  // ****
  // Helpers
  // ****
  function logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic chk(input string nm, input logic [31:0] seen,
                     input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask

  task automatic wt(input int k);
    repeat (k) @(posedge hclk);
  endtask

  // Single word transfer; only the watchdog ends a wait for hready
  task automatic ahb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= 32'(a);
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    r = hrdata;
  endtask

  task automatic meas(input logic pwr);
    logic p, c;
    on = 0;
    fl = 0;
    p = pwr ? power_lamp : error_lamp;
    repeat (32) begin
      @(posedge hclk);
      c = pwr ? power_lamp : error_lamp;
      on += (c === 1'b1);
      fl += (c !== p);
      p = c;
    end
  endtask

  task automatic press(input int k);
    lf = 0;
    ms = 0;
    feed_key <= 1'b1;
    for (int i = 0; i < k + 6; i++) begin
      @(posedge hclk);
      if (i == k - 1) feed_key <= 1'b0;
      lf += (line_feed === 1'b1);
      ms += (macro_start === 1'b1);
    end
  endtask

  task automatic wrap_up();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // ****
  // Main sequence
  // ****
  initial begin
    wt(2);
    hresetn <= 1'b1;
    wt(2);
    chk("self print", self_print, 1);
    feed_key <= 1'b0;
    wt(1);
    chk("self print end", self_print, 0);
    $display("power on test done");
    repeat (12) begin
      m = rnd();
      s = rnd();
      main_config_switch_bank <= m[9:0];
      serial_config_switch_bank <= s[7:0];
      serial_fitted <= m[31];
      if (!m[31]) s = 32'h0000_0000;
      b = 150;
      repeat (s[6:4]) b *= 2;
      wt(2);
      chk("density", density, m[9:8]);
      chk("charset", charset, m[7:5]);
      chk("baud", baud_rate, b);
      chk("serial", {xon_xoff, parity_even, parity_on, serial_bits7},
        s[3:0]);
      chk("flags", {cr_lf, cover_check, col44, cutter_enabled},
        {m[2], !m[1], m[4], m[0]});
      ahb(1'b0, 8'h08, 32'h0000_0000);
      chk("settings", r, {13'h0000, s[6:4], 3'h0, s[3:0], m[2],
        !m[1], m[0], m[4], m[7:5], m[9:8]});
    end
    ahb(1'b0, 8'h3c, 32'h0000_0000);
    chk("unmapped", r, 0);
    chk("okay", hresp, 0);
    main_config_switch_bank <= 10'h001;
    wt(2);
    $display("switch test done");
    chk("idle", {power_lamp, error_lamp, print_enable}, 3'h5);
    cover_open <= 1'b1;
    wt(2);
    chk("cover", {error_lamp, print_enable}, 2'h2);
    press(2);
    chk("cover feed", lf, 0);
    main_config_switch_bank <= 10'h003;
    wt(3);
    chk("cover off", {error_lamp, print_enable}, 2'h3);
    press(2);
    chk("cover off feed", lf, 1);
    cover_open <= 1'b0;
    main_config_switch_bank <= 10'h001;
    foreach (tt[i]) begin
      head_temp <= tt[i];
      wt(3);
      chk("heat", {error_lamp, print_enable}, pe[i] ? 2'h1 : 2'h2);
    end
    paper_near_end <= 1'b1;
    wt(2);
    chk("near end", {error_lamp, print_enable}, 2'h3);
    paper_near_end <= 1'b0;
    wt(2);
    chk("near end gone", error_lamp, 0);
    paper_out <= 1'b1;
    wt(2);
    chk("paper out", print_enable, 0);
    meas(1'b0);
    chk("paper out blink", fl, 8);
    paper_out <= 1'b0;
    wt(2);
    chk("load", load_start, 1);
    wt(1);
    chk("load end", load_start, 0);
    mem_check_fail <= 1'b1;
    wt(2);
    meas(1'b1);
    chk("mem blink", fl, 8);
    chk("mem lamp", error_lamp, 1);
    mem_check_fail <= 1'b0;
    wt(2);
    $display("lamp test done");
    press(1);
    chk("short feed", lf, 1);
    press(76);
    chk("held feed", lf, 5);
    ahb(1'b1, 8'h00, 32'h0000_0002);
    ahb(1'b0, 8'h00, 32'h0000_0000);
    chk("macro arm", r, 2);
    meas(1'b0);
    chk("macro blink", fl, 2);
    press(2);
    chk("macro start", {ms[1:0], lf[1:0]}, 4'h4);
    $display("feed test done");
    ahb(1'b1, 8'h00, 32'h0000_0001);
    wt(2);
    chk("cut run", {cutter_motor, print_enable}, 2'h2);
    n = 0;
    while (cutter_motor === 1'b1 && n++ < 40) wt(1);
    chk("cut done", {cutter_motor, cutter_lock}, 2'h0);
    ahb(1'b1, 8'h00, 32'h0000_0001);
    wt(2);
    jam <= 1'b1;
    n = 0;
    while (cutter_lock !== 1'b1 && n++ < 200) wt(1);
    chk("lock time", n >= LOCK - 2 && n <= LOCK + 4, 1);
    ahb(1'b0, 8'h04, 32'h0000_0000);
    chk("lock status", {r[11], r[9:4]}, 7'h24);
    meas(1'b0);
    chk("lock blink", on, 8);
    jam <= 1'b0;
    press(2);
    chk("lock clear", {cutter_lock, lf[0]}, 2'h0);
    ahb(1'b0, 8'h04, 32'h0000_0000);
    chk("cutter home", r[7:4], 4'h1);
    main_config_switch_bank <= 10'h000;
    wt(2);
    ahb(1'b1, 8'h00, 32'h0000_0001);
    wt(2);
    chk("cutter off", cutter_motor, 0);
    $display("cutter test done");
    wrap_up();
  end

  initial begin
    #(8 * 20000);
    miscompares++;
    wrap_up();
  end
endmodule // testbench
